// ===== psr_consts.vh
/*
  Constants of the pump status relay logic: register offsets, field
  positions, reset values and timing figures.
  Assumes a 20 MHz system clock; counts derive from the times below.
*/
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// register indices on the axi4-lite bus; byte address is four times the index
`define PSR_OFS_CTRL 4'h0
`define PSR_OFS_SETP 4'h1
`define PSR_OFS_FREQ 4'h2
`define PSR_OFS_STAT 4'h3
`define PSR_OFS_IRQS 4'h4
`define PSR_OFS_IRQM 4'h5

////////////////////////////////////////////////////////////////////////////////
// field positions
`define PSR_CTRL_SWSTOP 0
`define PSR_IRQ_NORMAL 0
`define PSR_IRQ_ERROR 1
`define PSR_IRQ_FAIL 2
`define PSR_IRQ_CMD 3
`define PSR_IRQ_W 4

////////////////////////////////////////////////////////////////////////////////
// reset values
`define PSR_RST_CTRL 1'h0
`define PSR_RST_SETP 16'h03e8
`define PSR_RST_IRQM 4'h0

////////////////////////////////////////////////////////////////////////////////
// threshold as a fraction: freq * den >= setpoint * num
`define PSR_THR_NUM 5'h09
`define PSR_THR_DEN 5'h0a

////////////////////////////////////////////////////////////////////////////////
// timing: clock rate, debounce time, flash half period
`define PSR_CLK_KHZ 20000
`define PSR_DEB_TIME_US 5000
`define PSR_DEB_CYC ((`PSR_DEB_TIME_US * `PSR_CLK_KHZ) / 1000)
`define PSR_FLASH_TIME_MS 500
`define PSR_FLASH_CYC (`PSR_FLASH_TIME_MS * `PSR_CLK_KHZ)

`endif

// ===== psr_debounce.v
/*
  Two-flop synchroniser followed by a debounce filter for one pin.
  Assumes the pin is asynchronous to sys_clk_i; the output changes only
  after the synchronised level stayed stable for HOLD_CYC cycles.
*/
`timescale 1ns/1ps
module psr_debounce #(
  parameter integer HOLD_CYC = 100000
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // raw pin and filtered level
  input wire pin_i,
  output reg level_o
);

  reg meta_q;
  reg sync_q;
  reg [23:0] cnt_q;

  // first flop is read by the second flop only
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // restart the count whenever the synchronised level agrees with the output, so bounce never passes
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 24'h000000;
      level_o <= 1'b0;
    end else if (sync_q == level_o) begin
      cnt_q <= 24'h000000;
    end else if (cnt_q >= HOLD_CYC - 1) begin
      cnt_q <= 24'h000000;
      level_o <= sync_q;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

endmodule

// ===== psr_tick_div.v
/*
  Divider that gives a one-cycle enable pulse every DIV_CYC clocks.
  Assumes DIV_CYC is at least 2 and fits in 24 bits.
*/
`timescale 1ns/1ps
module psr_tick_div #(
  parameter integer DIV_CYC = 1000
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // enable pulse
  output reg tick_o
);

  reg [23:0] cnt_q;

  // free-running count, pulse on wrap
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 24'h000000;
      tick_o <= 1'b0;
    end else if (cnt_q >= DIV_CYC - 1) begin
      cnt_q <= 24'h000000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
      tick_o <= 1'b0;
    end
  end

endmodule

// ===== psr_top.v
/*
  Pump status relay logic: decodes start/stop command, rotor turning,
  rotor frequency and error into drive enable, relays and indicators,
  with an axi4-lite register slave and one level interrupt.
  Assumes rotor_turning_i, rotor_freq_i and error_i come from logic on
  sys_clk_i; start_stop_i is a raw pin.
*/
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
// Overview of operation
// - drive on only with start and no error
// - normal frequency at ninety percent of setpoint
// - normal relay active: start, rotor turning, normal freq, no error
// - normal relay passive on stop, ramps, coast
// - error relay active exactly while error present
// - red error indicator follows error only
// - status led steady green in normal, flashing when otherwise turning, else off
// - undefined input/output combination flags controller failure
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_top #(
  parameter integer DEB_CYC = `PSR_DEB_CYC,
  parameter integer FLASH_CYC = `PSR_FLASH_CYC
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // pump conditions
  input wire start_stop_i,
  input wire rotor_turning_i,
  input wire [15:0] rotor_freq_i,
  input wire error_i,
  // drive, relays and indicators
  output reg motor_en_o,
  output reg relay_normal_o,
  output reg relay_error_o,
  output reg led_status_o,
  output reg led_error_o,
  output reg ctrl_fail_o,
  output reg irq_o,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;

  // pump operating modes, one-hot
  localparam [4:0] M_IDLE = 5'b00001;
  localparam [4:0] M_RAMP = 5'b00010;
  localparam [4:0] M_NORMAL = 5'b00100;
  localparam [4:0] M_ERROR = 5'b01000;
  localparam [4:0] M_FAIL = 5'b10000;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  wire start_deb;
  wire flash_tick;
  reg flash_q;
  reg ctrl_swstop_q;
  reg [15:0] setp_q;
  reg [3:0] irq_stat_q;
  reg [3:0] irq_stat_d;
  reg [3:0] irq_mask_q;
  reg [4:0] mode_q;
  reg [4:0] mode_d;
  reg cmd_q;
  reg aw_held_q;
  reg w_held_q;
  reg [3:0] aw_idx_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire cmd_start;
  wire at_norm;
  wire bad_input;
  wire bad_output;
  wire [20:0] freq_scaled;
  wire [20:0] setp_scaled;
  wire wr_fire;
  wire rd_fire;
  wire [3:0] rd_idx;
  reg [31:0] rd_data;
  reg rd_hit;

  //////////////////////////////////////////////////////////////////////////////
  // pin conditioning and slow timing

  // contact bounce would otherwise toggle the drive and the relays
  psr_debounce #(
    .HOLD_CYC(DEB_CYC)
  ) u_start_deb (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .pin_i(start_stop_i),
    .level_o(start_deb)
  );

  // flash rate for the status indicator
  psr_tick_div #(
    .DIV_CYC(FLASH_CYC)
  ) u_flash_div (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick_o(flash_tick)
  );

  // flash phase toggles on each divider pulse
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flash_q <= 1'b0;
    end else if (flash_tick) begin
      flash_q <= ~flash_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // condition decode

  // software stop overrides the pin, so a bus master can halt the pump
  assign cmd_start = start_deb & ~ctrl_swstop_q;

  // compare freq*10 against setpoint*9, avoiding a divider
  assign freq_scaled = rotor_freq_i * `PSR_THR_DEN;
  assign setp_scaled = setp_q * `PSR_THR_NUM;
  assign at_norm = (freq_scaled >= setp_scaled);

  // normal frequency without a turning rotor is not a listed state
  assign bad_input = at_norm & ~rotor_turning_i;

  // both relays active at once, drive on with error, or normal relay with drive off, cannot occur
  assign bad_output = (relay_normal_o & relay_error_o) |
                      (motor_en_o & relay_error_o) |
                      (relay_normal_o & ~motor_en_o);

  // operating mode from the present conditions
  always @* begin
    if (bad_input | bad_output) begin
      mode_d = M_FAIL;
    end else if (error_i) begin
      mode_d = M_ERROR;
    end else if (cmd_start & rotor_turning_i & at_norm) begin
      mode_d = M_NORMAL;
    end else if (rotor_turning_i | cmd_start) begin
      mode_d = M_RAMP;
    end else begin
      mode_d = M_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs

  // every output comes straight from a flop; one cycle after the inputs
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= M_IDLE;
      motor_en_o <= 1'b0;
      relay_normal_o <= 1'b0;
      relay_error_o <= 1'b0;
      led_status_o <= 1'b0;
      led_error_o <= 1'b0;
      ctrl_fail_o <= 1'b0;
      cmd_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cmd_q <= cmd_start;
      motor_en_o <= cmd_start & ~error_i;
      relay_normal_o <= cmd_start & rotor_turning_i & at_norm & ~error_i;
      relay_error_o <= error_i;
      led_error_o <= error_i;
      ctrl_fail_o <= (mode_d == M_FAIL);
      case (1'b1)
        // steady green only in normal operation
        (cmd_start & rotor_turning_i & at_norm & ~error_i): begin
          led_status_o <= 1'b1;
        end
        // flashing while turning in any other situation
        rotor_turning_i: begin
          led_status_o <= flash_q;
        end
        default: begin
          led_status_o <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status

  // events: entering normal, error rise, failure rise, command change;
  // a read clears the bits but a same-cycle event still sets them
  always @* begin
    irq_stat_d = irq_stat_q;
    if (rd_fire && rd_idx == `PSR_OFS_IRQS) begin
      irq_stat_d = 4'h0;
    end
    if (mode_d == M_NORMAL && mode_q != M_NORMAL) begin
      irq_stat_d[`PSR_IRQ_NORMAL] = 1'b1;
    end
    if (error_i && !relay_error_o) begin
      irq_stat_d[`PSR_IRQ_ERROR] = 1'b1;
    end
    if (mode_d == M_FAIL && !ctrl_fail_o) begin
      irq_stat_d[`PSR_IRQ_FAIL] = 1'b1;
    end
    if (cmd_start != cmd_q) begin
      irq_stat_d[`PSR_IRQ_CMD] = 1'b1;
    end
  end

  // sticky status and the level interrupt behind the mask
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_q <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_o <= |(irq_stat_d & irq_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;

  // address and data are taken independently, in either order
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[5:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (aw_idx_q <= `PSR_OFS_IRQM && s_axi_awaddr[31:6] == 26'h0000000) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_OKAY;
        end
        if (aw_idx_q > `PSR_OFS_IRQM) begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writable registers, byte lanes honoured
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_swstop_q <= `PSR_RST_CTRL;
      setp_q <= `PSR_RST_SETP;
      irq_mask_q <= `PSR_RST_IRQM;
    end else if (wr_fire) begin
      case (aw_idx_q)
        `PSR_OFS_CTRL: begin
          if (wstrb_q[0]) begin
            ctrl_swstop_q <= wdata_q[`PSR_CTRL_SWSTOP];
          end
        end
        `PSR_OFS_SETP: begin
          if (wstrb_q[0]) begin
            setp_q[7:0] <= wdata_q[7:0];
          end
          if (wstrb_q[1]) begin
            setp_q[15:8] <= wdata_q[15:8];
          end
        end
        `PSR_OFS_IRQM: begin
          if (wstrb_q[0]) begin
            irq_mask_q <= wdata_q[3:0];
          end
        end
        default: begin
          ctrl_swstop_q <= ctrl_swstop_q;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_idx = s_axi_araddr[5:2];

  // read mux; status shows live conditions and output state
  always @* begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    case (rd_idx)
      `PSR_OFS_CTRL: rd_data[0] = ctrl_swstop_q;
      `PSR_OFS_SETP: rd_data[15:0] = setp_q;
      `PSR_OFS_FREQ: rd_data[15:0] = rotor_freq_i;
      `PSR_OFS_STAT: begin
        rd_data[4:0] = mode_q;
        rd_data[8] = cmd_start;
        rd_data[9] = rotor_turning_i;
        rd_data[10] = at_norm;
        rd_data[11] = error_i;
        rd_data[16] = motor_en_o;
        rd_data[17] = relay_normal_o;
        rd_data[18] = relay_error_o;
        rd_data[19] = led_status_o;
        rd_data[20] = led_error_o;
        rd_data[21] = ctrl_fail_o;
      end
      `PSR_OFS_IRQS: rd_data[3:0] = irq_stat_q;
      `PSR_OFS_IRQM: rd_data[3:0] = irq_mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // one read outstanding; arready drops while the answer waits
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ===== psr_top_chk.sv
/*
  Checker for the pump status relay logic, bound to psr_top.
  Assumes each output registers the inputs of the previous clock edge.
*/
`timescale 1ns/1ps
module psr_top_chk (
  // clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // pump conditions
  input wire rotor_turning_i,
  input wire [15:0] rotor_freq_i,
  input wire error_i,
  // drive, relays and indicators
  input wire motor_en_o,
  input wire relay_normal_o,
  input wire relay_error_o,
  input wire led_status_o,
  input wire led_error_o,
  input wire ctrl_fail_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////////////
  // outputs against the inputs one edge earlier and against the other outputs
  chk_drive_err: assert property (
    $past(error_i) |-> !motor_en_o) else $error("drive on with error");
  chk_norm_cause: assert property (
    relay_normal_o |-> motor_en_o && $past(rotor_turning_i) && !$past(error_i))
    else $error("normal relay without cause");
  chk_norm_drive: assert property (
    !motor_en_o |-> !relay_normal_o) else $error("normal relay with drive off");
  // two-edge guard: the first edge after reset still shows reset values
  chk_err_relay: assert property (
    $past(rstn_i, 2) |-> relay_error_o == $past(error_i)) else $error("error relay wrong");
  chk_err_led: assert property (
    $changed(error_i) |=> led_error_o == $past(error_i)) else $error("error led wrong");
  chk_led_still: assert property (
    $past(rstn_i, 2) && !$past(rotor_turning_i) |-> !led_status_o)
    else $error("status led lit at standstill");
  chk_green_steady: assert property (
    relay_normal_o [*2] |-> led_status_o && $stable(led_status_o))
    else $error("green not steady");
  // full-scale frequency is above any setpoint threshold
  chk_fail_norm: assert property (
    $past(rstn_i, 2) && !$past(rotor_turning_i) && $past(rotor_freq_i) == 16'hffff
    |-> ctrl_fail_o) else $error("failure not flagged");
endmodule

// ===== psr_contacts.sv
/*
  Model of the switch contacts that drive the start/stop pin.
  Assumes close_i changes right after a clock edge; every change chatters.
*/
`timescale 1ns/1ps
module psr_contacts (
  // clock
  input wire sys_clk_i,
  // wanted contact state and pin level
  input wire close_i,
  output logic pin_o = 1'b0
);
  logic last_q = 1'b0;
  logic [1:0] bnc_q = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // chatter toggles each clock, so no bounce run ever outlasts the filter
  always @(posedge sys_clk_i) begin
    if (close_i !== last_q) begin
      last_q <= close_i;
      bnc_q <= 2'h3;
      pin_o <= close_i;
    end else if (bnc_q != 2'h0) begin
      bnc_q <= bnc_q - 2'h1;
      pin_o <= ~pin_o;
    end else begin
      pin_o <= last_q;
    end
  end
endmodule

// ===== psr_top_tb.sv
/*
  Self-checking bench for the pump status relay logic.
  Assumes psr_top with short filter and flash counts; start pin comes
  through the contact model, registers through axi4-lite.
*/
`timescale 1ns/1ps
module psr_top_tb;
  localparam int DEB = 4;
  localparam int FLS = 8;
  logic sys_clk_i, rstn_i, close, start_stop_i, rotor_turning_i, error_i;
  logic [15:0] rotor_freq_i;
  logic motor_en_o, relay_normal_o, relay_error_o, led_status_o, led_error_o, ctrl_fail_o, irq_o;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  int t;

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  psr_contacts psr_contacts_inst (.sys_clk_i, .close_i(close), .pin_o(start_stop_i));
  psr_top #(.DEB_CYC(DEB), .FLASH_CYC(FLS)) psr_top_inst (.sys_clk_i, .rstn_i, .start_stop_i,
    .rotor_turning_i, .rotor_freq_i, .error_i, .motor_en_o, .relay_normal_o, .relay_error_o,
    .led_status_o, .led_error_o, .ctrl_fail_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and waiting helpers
  task automatic complete_run;
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // counts status led changes; a flashing led toggles every FLS clocks
  task automatic blink(input int n);
    logic last;
    t = 0;
    last = led_status_o;
    repeat (n) begin
      @(posedge sys_clk_i);
      if (led_status_o !== last) t++;
      last = led_status_o;
    end
  endtask

  // cut a hang short; the whole run needs well under a thousand clocks
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      $display("mismatch at %0t: timeout", $time);
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite master: address and data offered together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bit aw, w;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk_i); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic regs_check;
    rd(32'h04);
    cmp(rd_d, 32'h000003e8, "setpoint reset");
    rd(32'h00);
    cmp(rd_d, 32'h0, "ctrl reset");
    rd(32'h14);
    cmp(rd_d, 32'h0, "mask reset");
    rd(32'h18);
    cmp(rsp, 2'b10, "unmapped read resp");
    cmp(rd_d, 32'h0, "unmapped read data");
    wr(32'h18, 32'h1);
    cmp(rsp, 2'b10, "unmapped write resp");
    rotor_freq_i <= 16'h0123;
    wr(32'h08, 32'hffff);
    rd(32'h08);
    cmp(rd_d, 32'h00000123, "freq read only");
    rotor_freq_i <= 16'h0000;
  endtask

  // a short closure is filtered out, a held one starts the drive
  task automatic start_check;
    @(posedge sys_clk_i);
    close <= 1'b1;
    @(posedge sys_clk_i);
    close <= 1'b0;
    step(20);
    cmp(motor_en_o, 1'b0, "glitch started drive");
    close <= 1'b1;
    step(4);
    cmp(motor_en_o, 1'b0, "drive before filter");
    step(16);
    cmp(motor_en_o, 1'b1, "drive on start");
    cmp(led_status_o, 1'b0, "led at standstill");
    cmp(relay_normal_o, 1'b0, "normal relay at standstill");
  endtask

  task automatic accel_check;
    rotor_turning_i <= 1'b1;
    rotor_freq_i <= 16'd100;
    blink(40);
    cmp(t >= 4, 1'b1, "led flashing on ramp");
    cmp(relay_normal_o, 1'b0, "normal relay on ramp");
  endtask

  // threshold at exactly nine tenths of two setpoints
  task automatic thresh_check;
    int sp;
    for (int i = 1; i <= 2; i++) begin
      sp = 1000 * i;
      wr(32'h04, sp);
      rotor_freq_i <= 16'(sp * 9 / 10 - 1);
      step(3);
      cmp(relay_normal_o, 1'b0, "normal below threshold");
      rotor_freq_i <= 16'(sp * 9 / 10);
      step(3);
      cmp(relay_normal_o, 1'b1, "normal at threshold");
      blink(24);
      cmp(t, 0, "green steady");
      cmp(led_status_o, 1'b1, "green lit");
      rd(32'h0c);
      cmp(rd_d, 32'h000b0704, "status in normal");
    end
  endtask

  // stop while the rotor still coasts at the threshold
  task automatic stop_check;
    wr(32'h00, 32'h1);
    step(2);
    cmp(motor_en_o, 1'b0, "drive with software stop");
    cmp(relay_normal_o, 1'b0, "normal with software stop");
    wr(32'h00, 32'h0);
    close <= 1'b0;
    step(20);
    cmp(motor_en_o, 1'b0, "drive after stop");
    cmp(relay_normal_o, 1'b0, "normal while coasting");
    blink(40);
    cmp(t >= 4, 1'b1, "led flashing while coasting");
    close <= 1'b1;
    step(20);
  endtask

  // error in normal operation, with the interrupt raised, cleared and masked
  task automatic error_check;
    rd(32'h10);
    cmp(rd_d, 32'h00000009, "events before error");
    wr(32'h14, 32'h2);
    error_i <= 1'b1;
    step(3);
    cmp(motor_en_o, 1'b0, "drive with error");
    cmp(relay_error_o, 1'b1, "error relay");
    cmp(led_error_o, 1'b1, "error led");
    cmp(relay_normal_o, 1'b0, "normal with error");
    cmp(irq_o, 1'b1, "irq raised");
    blink(40);
    cmp(t >= 4, 1'b1, "led flashing with error");
    rd(32'h10);
    cmp(rd_d[1], 1'b1, "error event bit");
    step(2);
    cmp(irq_o, 1'b0, "irq after read");
    error_i <= 1'b0;
    step(3);
    cmp(relay_error_o, 1'b0, "error relay released");
    cmp(led_error_o, 1'b0, "error led off");
    cmp(motor_en_o, 1'b1, "drive back on");
    wr(32'h14, 32'h0);
    error_i <= 1'b1;
    step(3);
    cmp(irq_o, 1'b0, "irq masked");
    error_i <= 1'b0;
    step(3);
  endtask

  task automatic fail_check;
    rotor_turning_i <= 1'b0;
    rotor_freq_i <= 16'hffff;
    step(3);
    cmp(ctrl_fail_o, 1'b1, "normal without rotation");
    rotor_freq_i <= 16'h0000;
    step(3);
    cmp(ctrl_fail_o, 1'b0, "defined state flagged");
    rd(32'h10);
    cmp(rd_d, 32'h00000007, "events after failure");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn_i = 1'b0;
    close = 1'b0;
    rotor_turning_i = 1'b0;
    error_i = 1'b0;
    rotor_freq_i = 16'h0000;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    step(12);
    rstn_i <= 1'b1;
    regs_check();
    start_check();
    accel_check();
    thresh_check();
    stop_check();
    error_check();
    fail_check();
    complete_run();
  end
endmodule

bind psr_top psr_top_chk psr_top_chk_inst (.sys_clk_i, .rstn_i, .rotor_turning_i, .rotor_freq_i,
  .error_i, .motor_en_o, .relay_normal_o, .relay_error_o, .led_status_o, .led_error_o,
  .ctrl_fail_o);
